/* src/emb_consts.svh */
// constants of the embedded multiplier block: offsets, fields, resets
// assumes inclusion by bare name from the package and the top module
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH

`define EMB_ADDR_W 8
`define EMB_OFS_CTRL 8'h00
`define EMB_OFS_STATUS 8'h04
`define EMB_OFS_RES_LO 8'h08
`define EMB_OFS_RES_HI 8'h0C

`define EMB_BIT_MODE 0
`define EMB_BIT_REG_A 1
`define EMB_BIT_REG_B 3
`define EMB_BIT_REG_SA 5
`define EMB_BIT_REG_SB 6
`define EMB_BIT_REG_RES 7
`define EMB_BIT_USE_SA 9
`define EMB_BIT_USE_SB 10
`define EMB_CTRL_W 11
`define EMB_CTRL_RESET 11'h000

`define EMB_SEC_W 9
`define EMB_OP_W 18
`define EMB_RES_W 36
`define EMB_RSEC_W 18

`define EMB_RESP_OKAY 2'h0
`define EMB_RESP_SLVERR 2'h2

`endif

/* src/emb_pkg.sv */
// types of the embedded multiplier block
// assumes the constants header is on the include path
package emb_pkg;
  `include "emb_consts.svh"

  typedef enum logic {
    EMB_MODE_WIDE = 1'b0,
    EMB_MODE_DUAL = 1'b1
  } emb_mode_t;

  typedef struct packed {
    logic use_sb;
    logic use_sa;
    logic [1:0] reg_res;
    logic reg_sb;
    logic reg_sa;
    logic [1:0] reg_b;
    logic [1:0] reg_a;
    emb_mode_t mode;
  } emb_cfg_t;

  typedef struct packed {
    logic [`EMB_OP_W-1:0] a;
    logic [`EMB_OP_W-1:0] b;
    logic sa;
    logic sb;
  } emb_ops_t;
endpackage

/* src/emb_mult_block.sv */
// embedded multiplier block: one 18x18 or two 9x9 multipliers with
// optional input, sign and result registers, configured over AXI4-Lite
// assumes one clock; operands are synchronous to CLOCK
`timescale 1ns/1ns
`include "emb_consts.svh"

module emb_mult_block
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // multiplier register controls
  input wire logic MUL_ENA,
  input wire logic MUL_ACLR,
  // operands and sign controls
  input wire logic [17:0] DATA_A,
  input wire logic [17:0] DATA_B,
  input wire logic SIGN_A,
  input wire logic SIGN_B,
  // products
  output logic [35:0] RESULT,
  output logic [1:0] RESULT_SIGNED,
  // axi4-lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // axi4-lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // axi4-lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // axi4-lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // axi4-lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP
);
  import emb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic [`EMB_CTRL_W-1:0] ctrl;
  emb_cfg_t cfg;
  logic wide;
  logic mul_clr;
  emb_ops_t ops_q;
  logic [17:0] a_in;
  logic [17:0] b_in;
  logic sa_eff;
  logic sb_eff;
  logic signed [18:0] wide_a;
  logic signed [18:0] wide_b;
  logic signed [37:0] wide_p;
  logic [35:0] prod;
  logic [35:0] res_q;
  logic res_sign_q;
  logic prod_sign;
  logic [1:0] dual_sign;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  assign cfg = emb_cfg_t'(ctrl);
  assign wide = (cfg.mode == EMB_MODE_WIDE);

  ////////////////////////////////////////////////////////////////////////
  // multiplier input registers

  // one clear, one enable and one clock for the input and result registers of the multiplier
  assign mul_clr = RESET | MUL_ACLR;

  always_ff @(posedge CLOCK or posedge mul_clr)
  begin
    if (mul_clr)
    begin
      ops_q <= '0;
    end
    else if (MUL_ENA)
    begin
      ops_q.a <= DATA_A;
      ops_q.b <= DATA_B;
      ops_q.sa <= SIGN_A;
      ops_q.sb <= SIGN_B;
    end
  end

  // per 9-bit section bypass; wide mode follows the low section's choice
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_in
      logic sel_a;
      logic sel_b;
      assign sel_a = wide ? cfg.reg_a[0] : cfg.reg_a[g];
      assign sel_b = wide ? cfg.reg_b[0] : cfg.reg_b[g];
      assign a_in[g*9 +: 9] = sel_a ? ops_q.a[g*9 +: 9]
                                    : DATA_A[g*9 +: 9];
      assign b_in[g*9 +: 9] = sel_b ? ops_q.b[g*9 +: 9]
                                    : DATA_B[g*9 +: 9];
    end
  endgenerate

  // a sign control left unused reads as unsigned
  assign sa_eff = cfg.use_sa
                  & (cfg.reg_sa ? ops_q.sa : SIGN_A);
  assign sb_eff = cfg.use_sb
                  & (cfg.reg_sb ? ops_q.sb : SIGN_B);

  ////////////////////////////////////////////////////////////////////////
  // multiplier stage

  // one extra bit carries the sign or a zero, so no product is cut
  assign wide_a = {sa_eff & a_in[17], a_in};
  assign wide_b = {sb_eff & b_in[17], b_in};
  assign wide_p = wide_a * wide_b;

  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_dual
      logic signed [9:0] da;
      logic signed [9:0] db;
      logic signed [19:0] dp;
      // both halves share the one pair of sign controls
      assign da = {sa_eff & a_in[g*9+8], a_in[g*9 +: 9]};
      assign db = {sb_eff & b_in[g*9+8], b_in[g*9 +: 9]};
      assign dp = da * db;
      assign dual_sign[g] = sa_eff | sb_eff;
    end
  endgenerate

  // mode picks one 36-bit product or two 18-bit ones
  always_comb
  begin
    if (wide)
    begin
      prod = wide_p[35:0];
    end
    else
    begin
      prod = {g_dual[1].dp[17:0], g_dual[0].dp[17:0]};
    end
  end

  assign prod_sign = sa_eff | sb_eff;

  ////////////////////////////////////////////////////////////////////////
  // result registers

  always_ff @(posedge CLOCK or posedge mul_clr)
  begin
    if (mul_clr)
    begin
      res_q <= '0;
      res_sign_q <= 1'b0;
    end
    else if (MUL_ENA)
    begin
      res_q <= prod;
      res_sign_q <= prod_sign;
    end
  end

  // two 18-bit sections, tied together as one 36-bit section in wide mode
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_out
      logic sel_r;
      assign sel_r = wide ? cfg.reg_res[0] : cfg.reg_res[g];
      assign RESULT[g*18 +: 18] = sel_r ? res_q[g*18 +: 18]
                                        : prod[g*18 +: 18];
      assign RESULT_SIGNED[g] = sel_r ? res_sign_q
                                      : dual_sign[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channels

  // address and data are taken in either order, one write at a time
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  assign do_write = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end
    else if (do_write)
    begin
      w_held <= 1'b0;
    end
  end

  // control register; only the byte lanes that are strobed change
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      ctrl <= `EMB_CTRL_RESET;
    end
    else if (do_write && {aw_addr[7:2], 2'h0} == `EMB_OFS_CTRL)
    begin
      if (w_strb[0])
      begin
        ctrl[7:0] <= w_data[7:0];
      end
      if (w_strb[1])
      begin
        ctrl[10:8] <= w_data[10:8];
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `EMB_RESP_OKAY;
    end
    else if (do_write)
    begin
      S_AXI_BVALID <= 1'b1;
      if ({aw_addr[7:2], 2'h0} == `EMB_OFS_CTRL)
      begin
        S_AXI_BRESP <= `EMB_RESP_OKAY;
      end
      else
      begin
        S_AXI_BRESP <= `EMB_RESP_SLVERR;
      end
    end
    else if (S_AXI_BREADY)
    begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channels

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_comb
  begin
    next_rdata = 32'h00000000;
    next_rresp = `EMB_RESP_OKAY;
    case ({S_AXI_ARADDR[7:2], 2'h0})
      `EMB_OFS_CTRL:
      begin
        next_rdata[`EMB_CTRL_W-1:0] = ctrl;
      end
      `EMB_OFS_STATUS:
      begin
        next_rdata[1:0] = RESULT_SIGNED;
        next_rdata[2] = sa_eff;
        next_rdata[3] = sb_eff;
      end
      `EMB_OFS_RES_LO:
      begin
        next_rdata = RESULT[31:0];
      end
      `EMB_OFS_RES_HI:
      begin
        next_rdata[3:0] = RESULT[35:32];
      end
      default:
      begin
        next_rresp = `EMB_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `EMB_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= next_rdata;
      S_AXI_RRESP <= next_rresp;
    end
    else if (S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule // emb_mult_block

/* tb/emb_mult_assert_assertions.sv */
// port checker of the multiplier block, bound to every instance
// assumes one clock and RESET asynchronous, active high
`timescale 1ns/1ns
module emb_mult_assert
(
  // clock, reset and datapath
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic MUL_ACLR,
  input wire logic [17:0] DATA_A,
  input wire logic [35:0] RESULT,
  // register bus
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  a_aclr_zero: assert property
    (MUL_ACLR && DATA_A == 18'h0 |-> RESULT == 36'h0)
    else $error("result not zero under clear");
  a_b_after: assert property
    (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  a_b_hold: assert property
    (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_w_busy: assert property
    (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response pending");
  a_r_after: assert property
    (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  a_r_hold: assert property
    (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_ar_busy: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while data pending");
  a_bad_addr: assert property
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:4] != 4'h0
      |=> S_AXI_RRESP == 2'h2)
    else $error("unmapped read not refused");
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_refused: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
  c_clear: cover property (MUL_ACLR && RESULT == 36'h0);
endmodule // emb_mult_assert

bind emb_mult_block emb_mult_assert chk_u (.*);

/* tb/emb_fabric_model.sv */
// fabric model: draws operands and sign controls for the multiplier
// assumes the bench raises step while new operands are wanted and
// drops it to get zero operands
`timescale 1ns/1ns
module emb_fabric_model
(
  // control
  input wire logic clock,
  input wire logic step,
  // operands
  output logic [17:0] data_a,
  output logic [17:0] data_b,
  output logic sign_a,
  output logic sign_b
);
  // extreme values of both modes are drawn often
  function automatic logic [17:0] pick();
    case ($urandom % 4)
      0: return 18'h20100;
      1: return 18'h3FFFF;
      default: return 18'($urandom);
    endcase
  endfunction

  initial
  begin
    {data_a, data_b, sign_a, sign_b} = 38'h0;
    void'($urandom(48498));
    forever
    begin
      @(posedge clock);
      if (step)
      begin
        data_a <= pick();
        data_b <= pick();
        {sign_a, sign_b} <= 2'($urandom);
      end
      else
      begin
        data_a <= 18'h0;
        data_b <= 18'h0;
      end
    end
  end
endmodule // emb_fabric_model

/* tb/tb_embedded_multiplier_block.sv */
// bench of the multiplier block: bus setup, operand streams, checks
// assumes the fabric model feeds operands and the checker is bound
`timescale 1ns/1ns
module tb_embedded_multiplier_block;
  import emb_pkg::*;
  logic CLOCK = 0, RESET = 1, MUL_ENA = 1, MUL_ACLR = 0, step = 0;
  logic [17:0] DATA_A, DATA_B;
  logic SIGN_A, SIGN_B, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID;
  logic [35:0] RESULT, ex, held;
  logic [1:0] RESULT_SIGNED, S_AXI_BRESP, S_AXI_RRESP, exs, rp;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, rdat;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic [2:0] S_AXI_AWPROT = 0, S_AXI_ARPROT = 0;
  logic [3:0][37:0] hist = '0;
  logic [10:0] cfg;
  logic [10:0] cfgs [8] = '{11'h000, 11'h600, 11'h601, 11'h606, 11'h618,
    11'h660, 11'h7FE, 11'h7FF};
  int num_errors = 0, n_compared = 0;

  emb_mult_block dut_u (.*);
  emb_fabric_model fab_u (.clock(CLOCK), .step(step), .data_a(DATA_A),
    .data_b(DATA_B), .sign_a(SIGN_A), .sign_b(SIGN_B));

  initial
    forever #50 CLOCK = ~CLOCK;

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [35:0] seen, logic [35:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [35:0] prod(logic [17:0] a, logic [17:0] b,
    logic sa, logic sb, logic dual);
    logic signed [37:0] w;
    logic signed [19:0] p0, p1;
    w = $signed({sa & a[17], a}) * $signed({sb & b[17], b});
    p0 = $signed({sa & a[8], a[8:0]}) * $signed({sb & b[8], b[8:0]});
    p1 = $signed({sa & a[17], a[17:9]}) * $signed({sb & b[17], b[17:9]});
    return dual ? {p1[17:0], p0[17:0]} : w[35:0];
  endfunction

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic a, w;
    a = 1;
    w = 1;
    // let an edge pass so no ready is lowered and raised in one step
    @(posedge CLOCK);
    S_AXI_AWADDR <= ad;
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    while (a || w)
    begin
      @(posedge CLOCK);
      if (S_AXI_AWREADY) a = 0;
      if (S_AXI_WREADY) w = 0;
      S_AXI_AWVALID <= a;
      S_AXI_WVALID <= w;
    end
    do @(posedge CLOCK); while (!S_AXI_BVALID);
    rp = S_AXI_BRESP;
    S_AXI_BREADY <= 0;
  endtask

  task automatic rd(input logic [7:0] ad);
    @(posedge CLOCK);
    S_AXI_ARADDR <= ad;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do @(posedge CLOCK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 0;
    do @(posedge CLOCK); while (!S_AXI_RVALID);
    rdat = S_AXI_RDATA;
    rp = S_AXI_RRESP;
    S_AXI_RREADY <= 0;
  endtask

  // one cycle of operand history and the result it predicts
  task automatic step_exp();
    int la, lb, ls;
    @(negedge CLOCK);
    hist = {hist[2:0], DATA_A, DATA_B, SIGN_A & cfg[9], SIGN_B & cfg[10]};
    la = cfg[1] + cfg[7];
    lb = cfg[3] + cfg[7];
    ls = cfg[5] + cfg[7];
    ex = prod(hist[la][37:20], hist[lb][19:2], hist[ls][1], hist[ls][0],
      cfg[0]);
    exs = {2{|hist[ls][1:0]}};
  endtask

  initial
  begin
    repeat (3) @(posedge CLOCK);
    RESET <= 0;
    rd(8'h00);
    chk("ctrl reset", 36'(rdat), 36'h0);
    rd(8'h40);
    chk("unmapped", 36'({rp, rdat}), 36'h200000000);
    wr(8'h04, 32'h1);
    chk("status write", 36'(rp), 36'h2);
    step <= 1;
    foreach (cfgs[i])
    begin
      cfg = cfgs[i];
      wr(8'h00, 32'(cfg));
      rd(8'h00);
      chk("ctrl", 36'(rdat), 36'(cfg));
      for (int j = 0; j < 16; j++)
      begin
        step_exp();
        if (j > 2)
        begin
          chk("product", RESULT, ex);
          chk("signed", 36'(RESULT_SIGNED), 36'(exs));
        end
      end
      @(posedge CLOCK);
    end
    MUL_ENA <= 0;
    step_exp();
    held = ex;
    repeat (3)
    begin
      @(negedge CLOCK);
      chk("held", RESULT, held);
    end
    // held result and signs read back over the bus while frozen
    rd(8'h08);
    chk("result low", 36'(rdat), 36'(held[31:0]));
    rd(8'h0C);
    chk("result high", 36'(rdat), 36'(held[35:32]));
    rd(8'h04);
    chk("status", 36'(rdat), 36'({hist[1][0], hist[1][1], exs}));
    @(posedge CLOCK);
    MUL_ACLR <= 1;
    step <= 0;
    @(negedge CLOCK);
    chk("cleared", RESULT, 36'h0);
    // zero operands under clear give the checker its antecedent
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
    chk("still cleared", RESULT, 36'h0);
    report_and_stop();
  end

  initial
  begin
    #(100 * 3000);
    num_errors++;
    report_and_stop();
  end
endmodule // tb_embedded_multiplier_block
